// ===== common/epa_pkg.sv
// shared constants and types for the emulated phy auto-negotiation block
package epa_pkg;

    // timing
    localparam int CLK_FREQ_MHZ     = 125;
    localparam int SOFT_RST_TIME_US = 102;
    localparam int SOFT_RST_CYCLES  = SOFT_RST_TIME_US * CLK_FREQ_MHZ;

    // emulated_basic_control fields
    localparam int CTRL_RESET_BIT   = 15;
    localparam int CTRL_SPEED_BIT   = 13;
    localparam int CTRL_AN_EN_BIT   = 12;
    localparam int CTRL_RESTART_BIT = 9;
    localparam int CTRL_DUPLEX_BIT  = 8;
    localparam logic [15:0] CTRL_RESET_VAL  = 16'h3100;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'h7d00;

    // emulated_basic_status fields
    localparam int STAT_AN_DONE_BIT = 5;
    localparam logic [15:0] STAT_FIXED_VAL = 16'h780d;

    // emulated_autoneg_expansion fields
    localparam int EXP_PAGE_RX_BIT    = 1;
    localparam int EXP_LP_AN_ABLE_BIT = 0;

    // advertisement and partner ability fields
    localparam int ADV_ASYM_BIT = 11;
    localparam int ADV_SYM_BIT  = 10;
    localparam int ADV_TECH_LSB = 5;
    localparam int ADV_TECH_MSB = 8;
    localparam logic [15:0] ADV_RESET_VAL    = 16'h01e1;
    localparam logic [15:0] ADV_WRITE_MASK   = 16'h0de0;
    localparam logic [15:0] ADV_SELECTOR_VAL = 16'h0001;
    localparam logic [15:0] PARTNER_RESET_VAL = 16'h0000;

    // technology ability vector: 100 full, 100 half, 10 full, 10 half
    localparam int TECH_100_FULL = 3;
    localparam int TECH_100_HALF = 2;
    localparam int TECH_10_FULL  = 1;
    localparam int TECH_10_HALF  = 0;
    localparam logic [3:0] TECH_ALL       = 4'hf;
    localparam logic [3:0] TECH_PARALLEL  = 4'h4;

    // chip_reset_control and power_management_control fields
    localparam int CHIP_RST_DIGITAL_BIT = 10;
    localparam int CHIP_RST_VPHY_BIT    = 3;
    localparam int PMT_EMULATED_PHY_SOFT_RESET_BIT     = 10;

    typedef enum logic [1:0] {
        AN_IDLE    = 2'b00,
        AN_PAGE    = 2'b01,
        AN_RESOLVE = 2'b10,
        AN_LATCH   = 2'b11
    } epa_an_state_t;

    typedef struct packed {
        logic        wr;
        logic [15:0] data;
    } epa_reg_wr_t;

    typedef struct packed {
        logic sel;
        logic tx_en;
        logic rx_en;
    } epa_manual_fc_t;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic tx_pause;
        logic rx_pause;
    } epa_port_state_t;

endpackage

// ===== verilog/epa_self_clear.sv
// self-clearing reset bit with a fixed hold time
`timescale 1ns/1ps
module epa_self_clear
    import epa_pkg::*;
#(
    parameter int CYCLES = SOFT_RST_CYCLES
) (
    input  wire logic ref_clk, // system clock
    input  wire logic reset,   // synchronous reset
    input  wire logic start,   // one-cycle start pulse
    output logic      busy_q   // bit reads one while held
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD_VAL = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end else if (start) begin
            busy_q <= 1'b1;
            cnt_q  <= LOAD_VAL;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule

// ===== verilog/epa_hcd.sv
// highest common ability resolver with parallel detect fallback
`timescale 1ns/1ps
module epa_hcd
    import epa_pkg::*;
(
    input  wire logic       ref_clk,       // system clock
    input  wire logic       reset,         // synchronous reset
    input  wire logic       load,          // sample abilities
    input  wire logic [3:0] local_tech,    // advertised abilities
    input  wire logic [3:0] partner_tech,  // partner abilities
    output logic            common_q,      // at least one in common
    output logic            speed_100_q,   // resolved speed
    output logic            full_duplex_q  // resolved duplex
);
    logic [3:0] common;

    assign common = local_tech & partner_tech;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            common_q      <= 1'b0;
            speed_100_q   <= 1'b0;
            full_duplex_q <= 1'b0;
        end else if (load) begin
            common_q <= |common;
            if (common[TECH_100_FULL]) begin
                speed_100_q   <= 1'b1;
                full_duplex_q <= 1'b1;
            end else if (common[TECH_100_HALF]) begin
                speed_100_q   <= 1'b1;
                full_duplex_q <= 1'b0;
            end else if (common[TECH_10_FULL]) begin
                speed_100_q   <= 1'b0;
                full_duplex_q <= 1'b1;
            end else if (common[TECH_10_HALF]) begin
                speed_100_q   <= 1'b0;
                full_duplex_q <= 1'b0;
            end else begin
                // parallel detect outcome
                speed_100_q   <= 1'b1;
                full_duplex_q <= 1'b0;
            end
        end
    end

endmodule

// ===== verilog/epa_autoneg.sv
// emulated phy register bank with emulated auto-negotiation
`timescale 1ns/1ps
// What this block does
// - negotiate only while enable bit set
// - control bit 9 write restarts negotiation
// - resets, digital reset, reload restart negotiation
// - completion sets status bit 5
// - completion sets page received, latches result
// - highest common ability, fixed priority order
// - advertisement resets all four, software writable
// - later advertisement edits wait for rerun
// - partner always offers all four abilities
// - no next page, fault, T4 bits
// - common ability: expansion bit 0, partner shown
// - none common: 100 half, one partner bit
// - disabled: speed bit 13, duplex bit 8
// - enabled: forced speed/duplex ignored
// - pause abilities from advertisement 10, 11
// - partner pause mirrors local pause bits
// - manual flow control when disabled or selected
// - manual flow control leaves advertisement alone
// - reset control bit 3, clears after 102us
// - control bit 15 resets, then reads zero
// - power control bit 10, clears after 102us
// - host mac local, fabric is partner
module epa_autoneg
    import epa_pkg::*;
#(
    parameter int SELF_CLEAR_CYCLES = SOFT_RST_CYCLES
) (
    input  wire logic            ref_clk,                   // system clock
    input  wire logic            reset,                     // power-on reset
    input  wire logic            hardware_reset_pin_n,      // async pin
    input  epa_reg_wr_t          basic_control_wr,          // control write
    input  epa_reg_wr_t          advertisement_wr,          // adv write
    input  epa_reg_wr_t          chip_reset_control_wr,     // chip_reset_control wr
    input  epa_reg_wr_t          power_management_wr,       // pmt write
    input  wire logic            reload_cmd,                // reload pulse
    input  epa_manual_fc_t       host_port_manual_flow_control, // manual fc
    output logic [15:0]          emulated_basic_control,    // control read
    output logic [15:0]          emulated_basic_status,     // status read
    output logic [15:0]          emulated_autoneg_advertisement, // adv read
    output logic [15:0]          emulated_partner_ability,  // partner read
    output logic [15:0]          emulated_autoneg_expansion, // exp read
    output logic [15:0]          chip_reset_control,        // chip_reset_control read
    output logic [15:0]          power_management_control,  // pmt read
    output epa_port_state_t      host_port_state            // port 0 state
);

    // pin synchroniser
    logic hw_meta_q;
    logic hw_sync_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hw_meta_q <= 1'b1;
            hw_sync_q <= 1'b1;
        end else begin
            hw_meta_q <= hardware_reset_pin_n;
            hw_sync_q <= hw_meta_q;
        end
    end

    // software reset sources
    logic chip_busy;
    logic pmt_busy;
    logic chip_start;
    logic pmt_start;
    logic ctrl_rst_q;

    assign chip_start = chip_reset_control_wr.wr
                      & chip_reset_control_wr.data[CHIP_RST_VPHY_BIT];
    assign pmt_start  = power_management_wr.wr
                      & power_management_wr.data[PMT_EMULATED_PHY_SOFT_RESET_BIT];

    epa_self_clear #(
        .CYCLES (SELF_CLEAR_CYCLES)
    ) u_chip_rst (
        .ref_clk (ref_clk),
        .reset   (reset),
        .start   (chip_start),
        .busy_q  (chip_busy)
    );

    epa_self_clear #(
        .CYCLES (SELF_CLEAR_CYCLES)
    ) u_pmt_rst (
        .ref_clk (ref_clk),
        .reset   (reset),
        .start   (pmt_start),
        .busy_q  (pmt_busy)
    );

    // one-cycle reset from control bit 15
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl_rst_q <= 1'b0;
        end else begin
            ctrl_rst_q <= basic_control_wr.wr
                        & basic_control_wr.data[CTRL_RESET_BIT];
        end
    end

    logic phy_rst_now;
    logic phy_rst_q;
    logic rst_release;

    assign phy_rst_now = ~hw_sync_q | chip_busy | pmt_busy | ctrl_rst_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phy_rst_q <= 1'b1;
        end else begin
            phy_rst_q <= phy_rst_now;
        end
    end

    assign rst_release = phy_rst_q & ~phy_rst_now;

    // restart triggers
    logic restart_wr;
    logic digital_rst;
    logic restart_evt;

    assign restart_wr  = basic_control_wr.wr
                       & basic_control_wr.data[CTRL_RESTART_BIT];
    assign digital_rst = chip_reset_control_wr.wr
                       & chip_reset_control_wr.data[CHIP_RST_DIGITAL_BIT];
    assign restart_evt = restart_wr | digital_rst | reload_cmd
                       | rst_release;

    // control register
    logic [15:0] ctrl_q;
    logic        an_en;

    assign an_en = ctrl_q[CTRL_AN_EN_BIT];

    always_ff @(posedge ref_clk) begin
        if (reset || phy_rst_now) begin
            ctrl_q <= CTRL_RESET_VAL;
        end else if (basic_control_wr.wr) begin
            // restart and reset bits never stored
            ctrl_q <= basic_control_wr.data & CTRL_WRITE_MASK;
        end
    end

    // advertisement register
    logic [15:0] adv_q;

    always_ff @(posedge ref_clk) begin
        if (reset || phy_rst_now) begin
            adv_q <= ADV_RESET_VAL;
        end else if (advertisement_wr.wr) begin
            // next page, fault, t4 kept clear
            adv_q <= (advertisement_wr.data & ADV_WRITE_MASK)
                   | ADV_SELECTOR_VAL;
        end
    end

    // negotiation request, held until the sequence starts
    logic          an_req_q;
    epa_an_state_t an_state_q;
    logic          an_start;

    assign an_start = (an_state_q == AN_IDLE) & an_req_q & an_en
                    & ~phy_rst_now & ~phy_rst_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            an_req_q <= 1'b1;
        end else if (phy_rst_now || restart_evt) begin
            an_req_q <= 1'b1;
        end else if (an_start) begin
            an_req_q <= 1'b0;
        end
    end

    // snapshot of advertisement at sequence start
    logic [3:0] snap_tech_q;
    logic       snap_sym_q;
    logic       snap_asym_q;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            snap_tech_q <= '0;
            snap_sym_q  <= 1'b0;
            snap_asym_q <= 1'b0;
        end else if (an_start) begin
            snap_tech_q <= adv_q[ADV_TECH_MSB:ADV_TECH_LSB];
            snap_sym_q  <= adv_q[ADV_SYM_BIT];
            snap_asym_q <= adv_q[ADV_ASYM_BIT];
        end
    end

    // resolver
    logic hcd_common;
    logic hcd_speed;
    logic hcd_full;

    epa_hcd u_hcd (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .load          (an_state_q == AN_PAGE),
        .local_tech    (snap_tech_q),
        .partner_tech  (TECH_ALL),
        .common_q      (hcd_common),
        .speed_100_q   (hcd_speed),
        .full_duplex_q (hcd_full)
    );

    always_ff @(posedge ref_clk) begin
        if (reset || phy_rst_now) begin
            an_state_q <= AN_IDLE;
        end else begin
            case (an_state_q)
                AN_IDLE: begin
                    if (an_start) begin
                        an_state_q <= AN_PAGE;
                    end
                end
                AN_PAGE:    an_state_q <= AN_RESOLVE;
                AN_RESOLVE: an_state_q <= AN_LATCH;
                AN_LATCH:   an_state_q <= AN_IDLE;
                default:    an_state_q <= AN_IDLE;
            endcase
        end
    end

    // status, expansion, partner and latched result
    logic        an_done_q;
    logic        page_rx_q;
    logic        lp_able_q;
    logic [15:0] partner_q;
    logic        res_speed_q;
    logic        res_full_q;
    logic        res_tx_pause_q;
    logic        res_rx_pause_q;

    always_ff @(posedge ref_clk) begin
        if (reset || phy_rst_now || an_start) begin
            an_done_q <= 1'b0;
        end else if (an_state_q == AN_PAGE) begin
            an_done_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || phy_rst_now || an_start) begin
            page_rx_q <= 1'b0;
        end else if (an_state_q == AN_RESOLVE) begin
            page_rx_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || phy_rst_now) begin
            lp_able_q      <= 1'b0;
            partner_q      <= PARTNER_RESET_VAL;
            res_speed_q    <= 1'b0;
            res_full_q     <= 1'b0;
            res_tx_pause_q <= 1'b0;
            res_rx_pause_q <= 1'b0;
        end else if (an_state_q == AN_LATCH) begin
            res_speed_q <= hcd_speed;
            res_full_q  <= hcd_full;
            lp_able_q   <= hcd_common;
            partner_q   <= ADV_SELECTOR_VAL;
            partner_q[ADV_TECH_MSB:ADV_TECH_LSB] <=
                hcd_common ? TECH_ALL : TECH_PARALLEL;
            partner_q[ADV_SYM_BIT]  <= snap_sym_q;
            partner_q[ADV_ASYM_BIT] <= snap_asym_q;
            res_tx_pause_q <= hcd_full & (snap_sym_q | snap_asym_q);
            res_rx_pause_q <= hcd_full & snap_sym_q;
        end
    end

    // host port operating state
    logic use_manual;
    logic op_speed;
    logic op_full;

    assign op_speed = an_en ? res_speed_q : ctrl_q[CTRL_SPEED_BIT];
    assign op_full  = an_en ? res_full_q  : ctrl_q[CTRL_DUPLEX_BIT];
    assign use_manual = ~an_en | host_port_manual_flow_control.sel;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            host_port_state <= '0;
        end else begin
            host_port_state.speed_100   <= op_speed;
            host_port_state.full_duplex <= op_full;
            host_port_state.tx_pause    <= use_manual
                ? host_port_manual_flow_control.tx_en : res_tx_pause_q;
            host_port_state.rx_pause    <= use_manual
                ? host_port_manual_flow_control.rx_en : res_rx_pause_q;
        end
    end

    // register read images
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            emulated_basic_control         <= CTRL_RESET_VAL;
            emulated_basic_status          <= STAT_FIXED_VAL;
            emulated_autoneg_advertisement <= ADV_RESET_VAL;
            emulated_partner_ability       <= PARTNER_RESET_VAL;
            emulated_autoneg_expansion     <= '0;
        end else begin
            emulated_basic_control <= ctrl_q;
            emulated_basic_status  <= STAT_FIXED_VAL;
            emulated_basic_status[STAT_AN_DONE_BIT] <= an_done_q;
            // advertisement never touched by manual fc
            emulated_autoneg_advertisement <= adv_q;
            emulated_partner_ability       <= partner_q;
            emulated_autoneg_expansion     <= '0;
            emulated_autoneg_expansion[EXP_PAGE_RX_BIT]    <= page_rx_q;
            emulated_autoneg_expansion[EXP_LP_AN_ABLE_BIT] <= lp_able_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            chip_reset_control       <= '0;
            power_management_control <= '0;
        end else begin
            chip_reset_control <= '0;
            chip_reset_control[CHIP_RST_VPHY_BIT] <= chip_busy;
            power_management_control <= '0;
            power_management_control[PMT_EMULATED_PHY_SOFT_RESET_BIT] <= pmt_busy;
        end
    end

endmodule

// ===== testbench/epa_autoneg_assertions.sv
// port-level checks for the emulated phy negotiation block
`timescale 1ns/1ps
module epa_autoneg_assertions
    import epa_pkg::*;
#(
    parameter int SELF_CLEAR_CYCLES = SOFT_RST_CYCLES
) (
    input wire logic        ref_clk,                        // clock
    input wire logic        reset,                          // reset
    input epa_manual_fc_t   host_port_manual_flow_control,  // manual fc
    input wire logic [15:0] emulated_basic_control,         // control
    input wire logic [15:0] emulated_basic_status,          // status
    input wire logic [15:0] emulated_autoneg_advertisement, // adv
    input wire logic [15:0] emulated_partner_ability,       // partner
    input wire logic [15:0] emulated_autoneg_expansion,     // expansion
    input wire logic [15:0] chip_reset_control,             // chip_reset_control
    input wire logic [15:0] power_management_control,       // pmt
    input epa_port_state_t  host_port_state                 // port state
);
    wire logic [15:0] ctl = emulated_basic_control;
    wire logic [15:0] sts = emulated_basic_status;
    wire logic [15:0] adv = emulated_autoneg_advertisement;
    wire logic [15:0] lp  = emulated_partner_ability;
    wire logic [15:0] exq = emulated_autoneg_expansion;
    wire logic [15:0] crc = chip_reset_control;
    wire logic [15:0] pmt = power_management_control;
    epa_manual_fc_t   fc;
    epa_port_state_t  hps;
    int               cnt_q;
    assign fc  = host_port_manual_flow_control;
    assign hps = host_port_state;

    // high time of the reset control self-clear bit
    always_ff @(posedge ref_clk) begin
        if (reset || !crc[3])
            cnt_q <= 0;
        else
            cnt_q <= cnt_q + 1;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_ctl_unstored: assert property (!ctl[15] && !ctl[9])
        else $error("control bit 15 or 9 reads one");
    a_adv_fixed: assert property (
        adv[15:12] == 4'h0 && !adv[9] && adv[4:0] == 5'h01)
        else $error("advertisement fixed bits wrong");
    a_lp_no_np: assert property (!lp[15] && !lp[13] && !lp[9])
        else $error("partner shows next page fault or t4");
    a_done_needs_en: assert property ($rose(sts[5]) |-> ctl[12])
        else $error("negotiation completed while disabled");
    a_page_follows: assert property ($rose(sts[5]) |=> $rose(exq[1]))
        else $error("page received not one cycle after done");
    a_lp_result: assert property (
        $rose(exq[1]) |=> (exq[0] ? lp[8:5] == TECH_ALL
                                  : lp[8:5] == TECH_PARALLEL))
        else $error("partner abilities wrong for result");
    a_pause_mirror: assert property (
        $rose(exq[1]) |=> lp[11:10] == adv[11:10])
        else $error("partner pause does not mirror");
    a_parallel_mode: assert property (
        $rose(exq[1]) ##1 !exq[0]
        |-> ##[0:1] (hps.speed_100 && !hps.full_duplex))
        else $error("parallel detect not 100 half");
    a_forced_mode: assert property (
        ($stable(ctl) && !ctl[12])[*4]
        |-> hps.speed_100 == ctl[13] && hps.full_duplex == ctl[8])
        else $error("forced speed or duplex not applied");
    a_manual_fc: assert property (
        ((!ctl[12] || fc.sel) && $stable(fc) && $stable(ctl)
         && $stable(hps.full_duplex))[*4] ##0 hps.full_duplex
        |-> hps.tx_pause == fc.tx_en && hps.rx_pause == fc.rx_en)
        else $error("manual flow control not applied");
    a_crc_len: assert property (
        $fell(crc[3]) |-> cnt_q >= SELF_CLEAR_CYCLES - 1
                          && cnt_q <= SELF_CLEAR_CYCLES + 1)
        else $error("reset control bit held wrong time");
    a_pmt_hold: assert property (
        $rose(pmt[10]) |-> pmt[10] [*8] ##[1:40] !pmt[10])
        else $error("power control reset bit hold wrong");

    c_parallel: cover property ($rose(exq[1]) ##1 !exq[0]);
    c_pmt_done: cover property ($fell(pmt[10]));
    c_forced: cover property (!ctl[12] && !hps.speed_100);
endmodule

// ===== testbench/epa_host_model.sv
// host driver model issuing one-cycle register write pulses
`timescale 1ns/1ps
module epa_host_model
    import epa_pkg::*;
(
    input wire logic ref_clk, // system clock
    output epa_reg_wr_t ctrl_wr,  // control write
    output epa_reg_wr_t adv_wr,   // advertisement write
    output epa_reg_wr_t crc_wr,   // reset control write
    output epa_reg_wr_t pmt_wr    // power control write
);
    epa_reg_wr_t w_q [4] = '{default: '0};
    assign ctrl_wr = w_q[0];
    assign adv_wr  = w_q[1];
    assign crc_wr  = w_q[2];
    assign pmt_wr  = w_q[3];

    // released data shows the inverse so stale values never match
    task automatic wr(input int k, input logic [15:0] d);
        @(negedge ref_clk);
        w_q[k] = '{wr: 1'b1, data: d};
        @(negedge ref_clk);
        w_q[k] = '{wr: 1'b0, data: ~d};
    endtask
endmodule

// ===== testbench/tb_emulated_phy_autoneg.sv
// self-checking bench for the emulated phy negotiation block
`timescale 1ns/1ps
module tb_emulated_phy_autoneg
    import epa_pkg::*;
;
    localparam int SC = 16;
    logic            ref_clk;
    logic            reset;
    logic            pin_n;
    logic            reload;
    epa_manual_fc_t  fc;
    epa_reg_wr_t     cw, aw, rw, pw;
    logic [15:0]     ctl, sts, adv, lp, exq, crc, pmt;
    epa_port_state_t hps;
    int              error_cnt;
    int              n_compared;

`define CHK(g, e) chk(16'(g), 16'(e))

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    epa_host_model i_host (.ref_clk, .ctrl_wr(cw), .adv_wr(aw),
                           .crc_wr(rw), .pmt_wr(pw));

    epa_autoneg #(.SELF_CLEAR_CYCLES(SC)) i_dut (
        .ref_clk, .reset, .hardware_reset_pin_n(pin_n),
        .basic_control_wr(cw), .advertisement_wr(aw),
        .chip_reset_control_wr(rw), .power_management_wr(pw),
        .reload_cmd(reload), .host_port_manual_flow_control(fc),
        .emulated_basic_control(ctl), .emulated_basic_status(sts),
        .emulated_autoneg_advertisement(adv),
        .emulated_partner_ability(lp), .emulated_autoneg_expansion(exq),
        .chip_reset_control(crc), .power_management_control(pmt),
        .host_port_state(hps));

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // {speed_100, full_duplex, tx_pause, rx_pause}; p is {asym, sym}
    function automatic logic [3:0] exp_port(input logic [3:0] t,
                                            input logic [1:0] p);
        logic [1:0] m;
        m = t[3] ? 2'b11 : t[2] ? 2'b10 : t[1] ? 2'b01 : t[0] ? 2'b00 : 2'b10;
        return {m, m[0] & (p[0] | p[1]), m[0] & p[0]};
    endfunction

    task automatic chk_neg(input logic [3:0] t, input logic [1:0] p);
        logic [3:0] lt;
        lt = (t == 4'h0) ? TECH_PARALLEL : TECH_ALL;
        `CHK(sts, STAT_FIXED_VAL | 16'h0020);
        `CHK(exq, {14'h0, 1'b1, t != 4'h0});
        `CHK(lp[8:5], lt);
        `CHK(lp[11:10], p);
        `CHK({lp[15], lp[13], lp[9]}, 3'h0);
        `CHK(hps, exp_port(t, p));
    endtask

    task automatic neg(input logic [15:0] c);
        i_host.wr(0, c);
        idle(10);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        reset = 1'b1;
        pin_n = 1'b1;
        reload = 1'b0;
        fc = '0;
        error_cnt = 0;
        n_compared = 0;
        void'($urandom(32'he63a));
        idle(2);
        `CHK(ctl, CTRL_RESET_VAL);
        `CHK(adv, ADV_RESET_VAL);
        `CHK(sts, STAT_FIXED_VAL);
        `CHK(lp, PARTNER_RESET_VAL);
        `CHK(exq, 16'h0000);
        reset = 1'b0;
        idle(10);
        chk_neg(TECH_ALL, 2'b00);
        $display("test reset done");

        for (int i = 0; i < 16; i++) begin
            logic [3:0]  t;
            logic [1:0]  p;
            logic [15:0] d;
            t = (i < 4) ? 4'((1 << i) >> 1) : 4'($urandom);
            p = 2'($urandom);
            d = 16'($urandom);
            d[11:10] = p;
            d[8:5] = t;
            i_host.wr(1, d);
            neg(16'h3300);
            `CHK(adv, {4'h0, p, 1'b0, t, 5'h01});
            chk_neg(t, p);
        end
        $display("test resolve done");

        i_host.wr(1, ADV_RESET_VAL);
        neg(16'h3300);
        i_host.wr(1, 16'h0021);
        idle(10);
        chk_neg(TECH_ALL, 2'b00);
        @(negedge ref_clk) reload = 1'b1;
        @(negedge ref_clk) reload = 1'b0;
        idle(10);
        chk_neg(4'h1, 2'b00);
        i_host.wr(1, 16'h0041);
        i_host.wr(2, 16'h0400);
        idle(10);
        `CHK(crc, 16'h0000);
        chk_neg(4'h2, 2'b00);
        i_host.wr(1, 16'h0081);
        pin_n = 1'b0;
        idle(4);
        pin_n = 1'b1;
        idle(14);
        `CHK(adv, ADV_RESET_VAL);
        chk_neg(TECH_ALL, 2'b00);
        $display("test restart done");

        for (int i = 0; i < 4; i++) begin
            fc = epa_manual_fc_t'({1'b0, 2'($urandom)});
            // restart while disabled must stay pending
            i_host.wr(0, {2'b00, i[1], 4'h1, i[0], 8'h00});
            idle(6);
            `CHK(hps[3:2], i[1:0]);
            if (i[0])
                `CHK(hps[1:0], {fc.tx_en, fc.rx_en});
        end
        neg(16'h1200);
        chk_neg(TECH_ALL, 2'b00);
        fc = '{sel: 1'b1, tx_en: 1'b1, rx_en: 1'b0};
        idle(6);
        `CHK(hps[1:0], 2'b10);
        `CHK(adv, ADV_RESET_VAL);
        fc = '0;
        $display("test forced done");

        for (int k = 2; k < 5; k++) begin
            int   n;
            logic b;
            i_host.wr(1, 16'h0c21);
            i_host.wr(k == 4 ? 0 : k, k == 2 ? 16'h0008 :
                      k == 3 ? 16'h0400 : 16'h8000);
            idle(2);
            n = 0;
            b = (k == 2) ? crc[3] : pmt[10];
            if (k < 4)
                `CHK(b, 1'b1);
            while (b === 1'b1 && n < 60) begin
                idle(1);
                n++;
                b = (k == 2) ? crc[3] : pmt[10];
            end
            if (k < 4)
                `CHK(n >= SC - 3 && n <= SC + 1, 1'b1);
            idle(10);
            `CHK(ctl, CTRL_RESET_VAL);
            `CHK(adv, ADV_RESET_VAL);
            chk_neg(TECH_ALL, 2'b00);
        end
        $display("test soft reset done");
        finish_test();
    end
endmodule

bind epa_autoneg epa_autoneg_assertions #(
    .SELF_CLEAR_CYCLES(SELF_CLEAR_CYCLES)
) i_chk (
    .ref_clk, .reset, .host_port_manual_flow_control,
    .emulated_basic_control, .emulated_basic_status,
    .emulated_autoneg_advertisement, .emulated_partner_ability,
    .emulated_autoneg_expansion, .chip_reset_control,
    .power_management_control, .host_port_state
);
